// *** verilog/xlat_prog_pkg.sv ***
// constants shared by both ends of the entry programming port
// assumes one 50 MHz clock that both ends share
package xlat_prog_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 20;
   localparam int CLEAR_CYCLES    = 68;
   localparam int STROBE_MIN_NS   = 30;
   localparam int STROBE_CYCLES   = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_TO_WR_NS  = 100;
   localparam int READY_TO_WR_CYC = (READY_TO_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int DATA_W     = 16;
   localparam int NUM_WORDS  = 7;
   localparam int INDEX_W    = 10;
   localparam int ENTRIES    = 1024;
   localparam int HEADER_W   = 28;
   localparam int OUT_W      = 64;
   localparam int MAX_CASCADE_ENTRIES = 4096;

   // ----------------------------------------------------------------
   // control word 1 fields
   // ----------------------------------------------------------------
   localparam int W1_INDEX_LSB  = 0;
   localparam int W1_FORMAT_BIT = 10;
   localparam int W1_INIT_BIT   = 11;
   localparam int W1_CASC_LSB   = 12;

   // ----------------------------------------------------------------
   // control word 3 fields
   // ----------------------------------------------------------------
   localparam int W3_VPI_W      = 12;
   localparam int W3_VCM_BIT    = 12;
   localparam int W3_VPM_BIT    = 13;
   localparam int W3_ENABLE_BIT = 15;

   // ----------------------------------------------------------------
   // match status fields
   // ----------------------------------------------------------------
   localparam int ST_READY_BIT = 0;
   localparam int ST_INDEX_LSB = 1;
   localparam int ST_VALID_BIT = 11;

   // ----------------------------------------------------------------
   // usage control port codes
   // ----------------------------------------------------------------
   localparam logic [3:0] UPC_IDLE  = 4'hf;
   localparam logic [3:0] UPC_START = 4'h0;

endpackage

// *** verilog/host_bus_if.sv ***
// sixteen bit processor port between the loading host and the translator
// assumes both ends run on the same clock; the shared data wire is resolved here
interface host_bus_if;
   logic [15:0] data_h2d;
   logic        host_oe;
   logic [15:0] data_d2h;
   logic        dev_oe;
   logic [15:0] data;
   logic        cs_n;
   logic        wr_n;
   logic        rd_n;
   logic        load_ready;

   // undriven wire floats high through the board pull-ups
   assign data = dev_oe ? data_d2h : (host_oe ? data_h2d : 16'hffff);

   modport device (
      input  data,
      input  cs_n,
      input  wr_n,
      input  rd_n,
      output data_d2h,
      output dev_oe,
      output load_ready
   );

   modport host (
      input  data,
      input  load_ready,
      output data_h2d,
      output host_oe,
      output cs_n,
      output wr_n,
      output rd_n
   );
endinterface

// *** verilog/upc_nibble_serializer.sv ***
// four nibble match report on the usage control port
// assumes start_i is a one cycle pulse and never arrives while a report runs
module upc_nibble_serializer #(
   parameter int INDEX_W = 10
) (
   input  wire logic               clk_i,
   input  wire logic               reset_i,
   input  wire logic               start_i,
   input  wire logic [1:0]         cascade_identifier_i,
   input  wire logic [INDEX_W-1:0] index_i,
   output logic [3:0]              nibble_o,
   output logic                    busy_o
);
   logic [2:0]  step_q;
   logic [11:0] shift_q;

   if (INDEX_W != 10) begin : g_chk
      $error("serializer packs exactly ten index bits");
   end

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         step_q   <= 3'h0;
         shift_q  <= 12'h000;
         nibble_o <= xlat_prog_pkg::UPC_IDLE;
      end else if (start_i) begin
         step_q   <= 3'h3;
         shift_q  <= {cascade_identifier_i, index_i};
         nibble_o <= xlat_prog_pkg::UPC_START;
      end else if (step_q != 3'h0) begin
         step_q   <= step_q - 3'h1;
         nibble_o <= shift_q[11:8];
         shift_q  <= {shift_q[7:0], 4'h0};
      end else begin
         nibble_o <= xlat_prog_pkg::UPC_IDLE;
      end
   end

   assign busy_o = start_i || (step_q != 3'h0);
endmodule

// *** verilog/xlat_entry_port.sv ***
// device end: entry programming port, match table and usage control report
// assumes host inputs are synchronous to clk_i and reset_i is synchronous
//
// Contract
// - idle port reads F, report starts after match
// - report opens with zero nibble then three
// - nibble order: id+top index, middle, low
// - port returns to F after fourth nibble
// - sixteen bit data, select, ready, strobes
// - after reset clear table, ready after 68
// - host waits for ready after reset
// - seven unaddressed writes step word pointer
// - writes count only with select low
// - seventh write drops ready, writes both tables
// - running translation finishes before update
// - host starts no update while ready low
// - init flag fills all 1024 entries
// - fill end clears flag, raises ready
// - match sets valid bit and index
// - word one index picks the entry
// - word one cascade id shown on match
// - up to four cascaded devices, 4096 entries
// - format select clear masks top four bits
// - disabled entry never matches
module xlat_entry_port #(
   parameter int ENTRIES = xlat_prog_pkg::ENTRIES,
   parameter int INDEX_W = xlat_prog_pkg::INDEX_W
) (
   input  wire logic                                clk_i,
   input  wire logic                                reset_i,
   host_bus_if.device                               bus,
   input  wire logic                                header_valid_i,
   input  wire logic [xlat_prog_pkg::HEADER_W-1:0]  header_i,
   input  wire logic                                upc_normal_i,
   output logic                                     match_valid_o,
   output logic [INDEX_W-1:0]                       match_index_o,
   output logic [xlat_prog_pkg::OUT_W-1:0]          translated_o,
   output logic [3:0]                               usage_control_port_o,
   output logic                                     upc_oe_o
);
   typedef enum logic [3:0] {
      ST_CLEAR = 4'b0001,
      ST_IDLE  = 4'b0010,
      ST_PEND  = 4'b0100,
      ST_FILL  = 4'b1000
   } dev_state_t;

   localparam int DW = xlat_prog_pkg::DATA_W;

   if (ENTRIES != (1 << INDEX_W) || ENTRIES * 4 > xlat_prog_pkg::MAX_CASCADE_ENTRIES) begin : g_chk
      $error("entry count must be two to the index width and fit four devices");
   end

   dev_state_t                      state_q;
   logic [6:0]                      clear_cnt_q;
   logic [INDEX_W-1:0]              fill_idx_q;
   logic [2:0]                      wptr_q;
   logic [DW-1:0]                   words_q [xlat_prog_pkg::NUM_WORDS];
   logic                            wr_n_prev_q;
   logic                            write_seen;
   logic                            table_we;
   logic [INDEX_W-1:0]              table_idx;
   logic                            cell_format_select_q;
   logic [1:0]                      cascade_identifier_q;
   logic [ENTRIES-1:0]              enable_q;
   logic [ENTRIES-1:0]              vpm_q;
   logic [ENTRIES-1:0]              vcm_q;
   logic [xlat_prog_pkg::HEADER_W-1:0] key_q [ENTRIES];
   logic [xlat_prog_pkg::OUT_W-1:0]    out_ram_q [ENTRIES];
   logic                            hit;
   logic [INDEX_W-1:0]              hit_idx;
   logic                            match_pulse_q;
   logic                            report_busy;
   logic                            xlat_busy;
   logic [DW-1:0]                   dout_q;
   logic                            read_q;

   // ----------------------------------------------------------------
   // write strobe detection and word pointer
   // ----------------------------------------------------------------
   // a write is taken on the rising edge of the strobe, so data is settled
   assign write_seen = !bus.cs_n && bus.wr_n && !wr_n_prev_q;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_n_prev_q <= 1'b1;
      end else begin
         wr_n_prev_q <= bus.wr_n;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wptr_q <= 3'h0;
      end else if (write_seen && state_q == ST_IDLE) begin
         wptr_q <= (wptr_q == 3'(xlat_prog_pkg::NUM_WORDS - 1)) ? 3'h0 : wptr_q + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (write_seen && state_q == ST_IDLE) begin
         words_q[wptr_q] <= bus.data;
      end else if (state_q == ST_FILL && fill_idx_q == INDEX_W'(ENTRIES - 1)) begin
         words_q[0][xlat_prog_pkg::W1_INIT_BIT] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // load sequencer
   // ----------------------------------------------------------------
   // writes while ready is low are dropped; a well behaved host never makes them
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q     <= ST_CLEAR;
         clear_cnt_q <= 7'h00;
         fill_idx_q  <= '0;
      end else begin
         unique case (state_q)
            ST_CLEAR: begin
               clear_cnt_q <= clear_cnt_q + 7'h01;
               if (clear_cnt_q == 7'(xlat_prog_pkg::CLEAR_CYCLES - 1)) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (write_seen && wptr_q == 3'(xlat_prog_pkg::NUM_WORDS - 1)) begin
                  state_q <= ST_PEND;
               end
            end
            ST_PEND: begin
               if (!xlat_busy) begin
                  fill_idx_q <= '0;
                  state_q    <= words_q[0][xlat_prog_pkg::W1_INIT_BIT] ? ST_FILL : ST_IDLE;
               end
            end
            ST_FILL: begin
               fill_idx_q <= fill_idx_q + 1'b1;
               if (fill_idx_q == INDEX_W'(ENTRIES - 1)) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   assign bus.load_ready = (state_q == ST_IDLE);

   // ----------------------------------------------------------------
   // table writes
   // ----------------------------------------------------------------
   assign table_we  = (state_q == ST_PEND && !xlat_busy && !words_q[0][xlat_prog_pkg::W1_INIT_BIT])
                      || state_q == ST_FILL;
   assign table_idx = (state_q == ST_FILL) ? fill_idx_q
                      : words_q[0][xlat_prog_pkg::W1_INDEX_LSB +: INDEX_W];

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cell_format_select_q <= 1'b0;
         cascade_identifier_q <= 2'h0;
      end else if (table_we) begin
         cell_format_select_q <= words_q[0][xlat_prog_pkg::W1_FORMAT_BIT];
         cascade_identifier_q <= words_q[0][xlat_prog_pkg::W1_CASC_LSB +: 2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (state_q == ST_CLEAR) begin
         enable_q <= '0;
      end else if (table_we) begin
         enable_q[table_idx] <= words_q[2][xlat_prog_pkg::W3_ENABLE_BIT];
      end
   end

   // cam and output ram written in the same cycle to keep the update short
   always_ff @(posedge clk_i) begin
      if (table_we) begin
         vpm_q[table_idx]     <= words_q[2][xlat_prog_pkg::W3_VPM_BIT];
         vcm_q[table_idx]     <= words_q[2][xlat_prog_pkg::W3_VCM_BIT];
         key_q[table_idx]     <= {words_q[2][xlat_prog_pkg::W3_VPI_W-1:0], words_q[1]};
         out_ram_q[table_idx] <= {words_q[6], words_q[5], words_q[4], words_q[3]};
      end
   end

   // ----------------------------------------------------------------
   // match search, lowest index wins
   // ----------------------------------------------------------------
   always_comb begin
      hit     = 1'b0;
      hit_idx = '0;
      for (int i = ENTRIES - 1; i >= 0; i--) begin
         if (enable_q[i]
             && (vcm_q[i] || header_i[15:0] == key_q[i][15:0])
             && (vpm_q[i] || header_i[23:16] == key_q[i][23:16])
             && (!cell_format_select_q || vpm_q[i]
                 || header_i[27:24] == key_q[i][27:24])) begin
            hit     = 1'b1;
            hit_idx = INDEX_W'(i);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         match_valid_o <= 1'b0;
         match_pulse_q <= 1'b0;
         match_index_o <= '0;
         translated_o  <= '0;
      end else begin
         match_pulse_q <= header_valid_i && hit;
         if (header_valid_i) begin
            match_valid_o <= hit;
         end
         if (header_valid_i && hit) begin
            match_index_o <= hit_idx;
            translated_o  <= out_ram_q[hit_idx];
         end
      end
   end

   // a translation counts as running from the header strobe until the fourth report nibble appears
   assign xlat_busy = header_valid_i || match_pulse_q || report_busy;

   // ----------------------------------------------------------------
   // usage control port
   // ----------------------------------------------------------------
   upc_nibble_serializer #(
      .INDEX_W (INDEX_W)
   ) u_upc (
      .clk_i                (clk_i),
      .reset_i              (reset_i),
      .start_i              (match_pulse_q),
      .cascade_identifier_i (cascade_identifier_q),
      .index_i              (match_index_o),
      .nibble_o             (usage_control_port_o),
      .busy_o               (report_busy)
   );

   assign upc_oe_o = upc_normal_i;

   // ----------------------------------------------------------------
   // status read
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dout_q <= 16'h0000;
         read_q <= 1'b0;
      end else begin
         read_q <= !bus.cs_n && !bus.rd_n;
         dout_q <= 16'h0000;
         dout_q[xlat_prog_pkg::ST_READY_BIT] <= (state_q == ST_IDLE);
         dout_q[xlat_prog_pkg::ST_INDEX_LSB +: INDEX_W] <= match_index_o;
         dout_q[xlat_prog_pkg::ST_VALID_BIT] <= match_valid_o;
      end
   end

   assign bus.data_d2h = dout_q;
   assign bus.dev_oe   = read_q && !bus.cs_n && !bus.rd_n;
endmodule

// *** verilog/xlat_entry_loader.sv ***
// host end: loads one entry as seven writes and reads the match status
// assumes the device end shares clk_i and answers reads one cycle after the strobe
module xlat_entry_loader (
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   host_bus_if.host           bus,
   input  wire logic          load_i,
   input  wire logic [111:0]  entry_words_i,
   input  wire logic          read_i,
   output logic               busy_o,
   output logic [15:0]        status_o,
   output logic               read_done_o
);
   typedef enum logic [5:0] {
      HS_IDLE   = 6'b000001,
      HS_WAIT   = 6'b000010,
      HS_STROBE = 6'b000100,
      HS_HOLD   = 6'b001000,
      HS_GAP    = 6'b010000,
      HS_READ   = 6'b100000
   } host_state_t;

   localparam int SCNT = xlat_prog_pkg::STROBE_CYCLES;
   localparam int RCNT = xlat_prog_pkg::READY_TO_WR_CYC;

   host_state_t   state_q;
   logic [111:0]  words_q;
   logic [2:0]    word_cnt_q;
   logic [3:0]    cnt_q;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q     <= HS_IDLE;
         words_q     <= '0;
         word_cnt_q  <= 3'h0;
         cnt_q       <= 4'h0;
         status_o    <= 16'h0000;
         read_done_o <= 1'b0;
      end else begin
         read_done_o <= 1'b0;
         unique case (state_q)
            HS_IDLE: begin
               cnt_q <= 4'h0;
               if (load_i) begin
                  words_q    <= entry_words_i;
                  word_cnt_q <= 3'h0;
                  state_q    <= HS_WAIT;
               end else if (read_i) begin
                  state_q <= HS_READ;
               end
            end
            HS_WAIT: begin
               // ready must stand for a settling time before the first strobe
               cnt_q <= bus.load_ready ? cnt_q + 4'h1 : 4'h0;
               if (bus.load_ready && cnt_q == 4'(RCNT - 1)) begin
                  cnt_q   <= 4'h0;
                  state_q <= HS_STROBE;
               end
            end
            HS_STROBE: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'(SCNT - 1)) begin
                  state_q <= HS_HOLD;
               end
            end
            HS_HOLD: begin
               cnt_q   <= 4'h0;
               state_q <= HS_GAP;
            end
            HS_GAP: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'(SCNT - 1)) begin
                  cnt_q      <= 4'h0;
                  words_q    <= {16'h0000, words_q[111:16]};
                  word_cnt_q <= word_cnt_q + 3'h1;
                  state_q    <= (word_cnt_q == 3'(xlat_prog_pkg::NUM_WORDS - 1)) ? HS_IDLE
                                                                                  : HS_STROBE;
               end
            end
            HS_READ: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'(SCNT)) begin
                  status_o    <= bus.data;
                  read_done_o <= 1'b1;
                  state_q     <= HS_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   assign bus.cs_n     = !(state_q == HS_STROBE || state_q == HS_HOLD || state_q == HS_READ);
   assign bus.wr_n     = (state_q != HS_STROBE);
   assign bus.rd_n     = (state_q != HS_READ);
   assign bus.data_h2d = words_q[15:0];
   assign bus.host_oe  = (state_q == HS_STROBE || state_q == HS_HOLD);
   assign busy_o       = (state_q != HS_IDLE);
endmodule

// *** bench/xlat_prog_sva.sv ***
// checker for the host bus and the usage control report of the translator
// assumes it sits beside the joining interface; one clock, sync reset
module xlat_prog_sva (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        cs_n,
   input  wire logic        wr_n,
   input  wire logic        rd_n,
   input  wire logic        dev_oe,
   input  wire logic [15:0] data_d2h,
   input  wire logic        load_ready,
   input  wire logic        header_valid_i,
   input  wire logic        match_valid_o,
   input  wire logic [9:0]  match_index_o,
   input  wire logic [3:0]  usage_control_port_o
);
   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   logic [6:0]  clr_q;
   logic [10:0] low_q;
   logic [2:0]  ptr_q;
   logic        wr_n_q;
   logic        take;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // own word pointer, so a miscounted sequence shows as a late ready drop
   assign take = !cs_n && wr_n && !wr_n_q && load_ready;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         clr_q  <= 7'h00;
         low_q  <= 11'h000;
         ptr_q  <= 3'h0;
         wr_n_q <= 1'b1;
      end else begin
         wr_n_q <= wr_n;
         clr_q  <= (clr_q == 7'h7f) ? clr_q : clr_q + 7'h01;
         low_q  <= load_ready ? 11'h000 : ((low_q == 11'h7ff) ? low_q : low_q + 11'h001);
         if (take) ptr_q <= (ptr_q == 3'h6) ? 3'h0 : ptr_q + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   AST_CLEAR_LOW: assert property (clr_q < 7'h44 |-> !load_ready)
      else $error("ready high during table clear");
   AST_CLEAR_DONE: assert property (clr_q == 7'h44 |-> load_ready)
      else $error("ready not raised after clear");
   AST_SEVENTH_DROP: assert property (take && ptr_q == 3'h6 |=> !load_ready)
      else $error("ready kept after seventh write");
   AST_READY_BOUND: assert property (!load_ready |-> low_q < 11'h4b0)
      else $error("ready low too long");
   AST_UPC_START: assert property (header_valid_i ##1 match_valid_o |->
      usage_control_port_o == 4'hf ##1 usage_control_port_o == 4'h0)
      else $error("report start wrong");
   AST_UPC_NIBBLES: assert property (header_valid_i ##1 match_valid_o |->
      ##2 usage_control_port_o[1:0] == match_index_o[9:8]
      ##1 usage_control_port_o == match_index_o[7:4]
      ##1 usage_control_port_o == match_index_o[3:0])
      else $error("report nibbles wrong");
   AST_UPC_RETURN: assert property (header_valid_i ##1 match_valid_o |->
      ##5 usage_control_port_o == 4'hf)
      else $error("port not back to idle");
   AST_READ_OE: assert property ((!cs_n && !rd_n) [*2] |-> dev_oe)
      else $error("read not answered");
   AST_OE_RELEASE: assert property ((cs_n || rd_n) [*2] |-> !dev_oe)
      else $error("data driven outside read");
   AST_STATUS_PAD: assert property (dev_oe |-> data_d2h[15:12] == 4'h0)
      else $error("status spare bits set");

   cover property ($rose(load_ready));
   cover property (take && ptr_q == 3'h6);
   cover property (header_valid_i ##1 match_valid_o);
   cover property (!cs_n && !rd_n);
endmodule

// *** bench/testbench.sv ***
// self-checking bench: loader and entry port joined by the host bus
// assumes one 50 MHz clock; inputs move 1 ns after the rising edge
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic         clk_i = 1'b0;
   logic         reset_i = 1'b1;
   logic         header_valid_i = 1'b0;
   logic [27:0]  header_i = 28'h0000000;
   logic         load_i = 1'b0;
   logic [111:0] entry_words_i = 112'h0;
   logic         read_i = 1'b0;
   logic         match_valid_o;
   logic         upc_oe_o;
   logic         busy_o;
   logic         read_done_o;
   logic [9:0]   match_index_o;
   logic [63:0]  translated_o;
   logic [3:0]   usage_control_port_o;
   logic [15:0]  status_o;
   int           error_cnt = 0;
   int           comparisons = 0;
   int           cyc = 0;

   host_bus_if bus_if ();
   always #10 clk_i = ~clk_i;

   xlat_entry_port u_xlat_entry_port (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if.device),
      .header_valid_i(header_valid_i), .header_i(header_i), .upc_normal_i(1'b1),
      .match_valid_o(match_valid_o), .match_index_o(match_index_o),
      .translated_o(translated_o), .usage_control_port_o(usage_control_port_o),
      .upc_oe_o(upc_oe_o));
   xlat_entry_loader u_xlat_entry_loader (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if.host),
      .load_i(load_i), .entry_words_i(entry_words_i), .read_i(read_i), .busy_o(busy_o),
      .status_o(status_o), .read_done_o(read_done_o));
   xlat_prog_sva u_xlat_prog_sva (.clk_i(clk_i), .reset_i(reset_i), .cs_n(bus_if.cs_n),
      .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .dev_oe(bus_if.dev_oe),
      .data_d2h(bus_if.data_d2h), .load_ready(bus_if.load_ready),
      .header_valid_i(header_valid_i), .match_valid_o(match_valid_o),
      .match_index_o(match_index_o), .usage_control_port_o(usage_control_port_o));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // whole run is near 1600 cycles; the ceiling only catches a hang
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         $display("MISMATCH t=%0t timeout", $time);
         print_verdict();
      end
   end

   task automatic step;
      @(posedge clk_i);
      #1;
   endtask

   task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   function automatic logic [63:0] out_of(input logic [9:0] idx);
      return {4{6'h00, idx}} ^ 64'h0f1e_2d3c_4b5a_6978;
   endfunction

   // low counts every cycle of ready low from the load pulse until all settles
   task automatic load_entry(input logic [9:0] idx, input logic fmt, input logic init,
      input logic [1:0] casc, input logic en, input logic [27:0] key, output int low);
      low = 0;
      entry_words_i = {out_of(idx), en, 3'h0, key[27:16], key[15:0], 2'h0, casc, init, fmt, idx};
      load_i = 1'b1;
      step();
      load_i = 1'b0;
      for (int i = 0; i < 3000 && (busy_o !== 1'b0 || bus_if.load_ready !== 1'b1); i++) begin
         if (bus_if.load_ready !== 1'b1) low++;
         if (low == 4) header_valid_i = 1'b0;
         step();
      end
   endtask

   task automatic send_hdr(input logic [27:0] key, input logic hit, input logic [9:0] idx,
      input logic [1:0] casc);
      logic [3:0] nib [6];
      nib = '{4'hf, 4'h0, {casc, idx[9:8]}, idx[7:4], idx[3:0], 4'hf};
      header_i = key;
      header_valid_i = 1'b1;
      step();
      header_valid_i = 1'b0;
      cmp_val(match_valid_o, hit, "valid");
      if (hit) begin
         cmp_val(match_index_o, idx, "index");
         cmp_val(translated_o, out_of(idx), "output ram");
      end
      for (int k = 0; k < 6; k++) begin
         cmp_val(usage_control_port_o, hit ? nib[k] : 4'hf, "usage port");
         step();
      end
   endtask

   task automatic read_status(input logic [15:0] exp);
      read_i = 1'b1;
      step();
      read_i = 1'b0;
      for (int i = 0; i < 50 && read_done_o !== 1'b1; i++) step();
      cmp_val(status_o, exp, "status");
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_clear;
      int n;
      n = 0;
      repeat (10) step();
      reset_i = 1'b0;
      while (n < 200 && bus_if.load_ready !== 1'b1) begin
         step();
         n++;
      end
      cmp_val(n, xlat_prog_pkg::CLEAR_CYCLES, "clear length");
      cmp_val(upc_oe_o, 1'b1, "port enable");
   endtask

   task automatic t_match;
      int low;
      logic [9:0] idx;
      logic [27:0] key;
      for (int c = 0; c < 4; c++) begin
         idx = {2'(3 - c), 8'h5a};
         key = 28'h1204560 + 28'(c);
         load_entry(idx, 1'b1, 1'b0, 2'(c), 1'b1, key, low);
         cmp_val(low > 0 && low < 8, 1'b1, "update time");
         send_hdr(key, 1'b1, idx, 2'(c));
      end
      read_status({4'h0, 1'b1, idx, 1'b1});
   endtask

   task automatic t_mask;
      int low;
      load_entry(10'h003, 1'b0, 1'b0, 2'h0, 1'b1, 28'h0cd1111, low);
      send_hdr(28'h5cd1111, 1'b1, 10'h003, 2'h0);
      load_entry(10'h004, 1'b1, 1'b0, 2'h0, 1'b1, 28'h0ee2222, low);
      send_hdr(28'h5ee2222, 1'b0, 10'h004, 2'h0);
      send_hdr(28'h0ee2222, 1'b1, 10'h004, 2'h0);
      // a missed header held across the seventh write keeps the update pending
      header_i = 28'h0773333;
      header_valid_i = 1'b1;
      load_entry(10'h005, 1'b1, 1'b0, 2'h0, 1'b0, 28'h0773333, low);
      cmp_val(low, 4, "update held");
      send_hdr(28'h0773333, 1'b0, 10'h005, 2'h0);
   endtask

   task automatic t_fill;
      int low;
      load_entry(10'h000, 1'b1, 1'b1, 2'h1, 1'b1, 28'h0aabeef, low);
      cmp_val(low >= xlat_prog_pkg::ENTRIES && low <= xlat_prog_pkg::ENTRIES + 8, 1'b1,
         "fill time");
      send_hdr(28'h0aabeef, 1'b1, 10'h000, 2'h1);
      send_hdr(28'h0cd1111, 1'b0, 10'h003, 2'h1);
      load_entry(10'h3ff, 1'b1, 1'b0, 2'h2, 1'b1, 28'h0bb0001, low);
      cmp_val(low > 0 && low < 8, 1'b1, "flag cleared");
      send_hdr(28'h0bb0001, 1'b1, 10'h3ff, 2'h2);
      read_status({4'h0, 1'b1, 10'h3ff, 1'b1});
   endtask

   initial begin
      t_clear();
      t_match();
      t_mask();
      t_fill();
      print_verdict();
   end
endmodule
